//--- rtl/ffs_pkg.sv
// Constants, register map and timing for the fail-safe fault supervisor
// Summary of operation
// - Supply below low-supply threshold sets low-supply flag and global error flag.
// - Clear bits are self-clearing and read back as zero after taking effect.
// - Low-supply and error flags stay latched; master writes fault clear to reset.
// - Low supply suppresses open-circuit detection.
// - Low-supply threshold code selects 4 V to 35 V in 1 V steps.
// - Supply undervoltage holds error pin low, sets undervoltage and error flags.
// - Undervoltage disables all outputs; recovery re-enables and releases pin, flags latched.
// - Reference open or short raises fault, holds pin low, sets reference and error flags.
// - Reference fault turns off all channels; enabled channels return after removal.
// - Pin released after reference fault clears; flags held until fault clear.
// - Pre-thermal trip sets pre-thermal and error flags, latched until fault clear.
// - First overtemperature turns off outputs, holds pin low, sets flags.
// - Overtemperature recovery restores outputs and pin; flags need fault clear.
// - Second overtemperature shuts regulator, pulls pin low; recovery restarts from reset.
// - Power-on clear write clears power-on and error flags, then bit returns to zero.
// - Open monitoring only in PWM on-time longer than blanking plus deglitch.
// - No open-circuit detection or report while supply is below low-supply threshold.
// - Persistent low headroom with good supply sets open, output and error flags, pin low.
// - Open channel stops normal drive and gets a retry pulse every 10 ms.
// - Retry current is (code*4+4)/64 of full range, code 0 to 15.
// - Retried channel resumes when headroom recovers or low supply occurs.
// - Open, output-fault and error flags stay latched until fault clear.
package ffs_pkg;

   localparam int unsigned NCH            = 16;
   localparam int unsigned CLK_HZ         = 40_000_000;

   // Register word addresses (the byte address is four times the index)
   localparam logic [3:0] ADDR_FLAGS      = 4'h0;
   localparam logic [3:0] ADDR_OPEN_FLAGS = 4'h1;
   localparam logic [3:0] ADDR_CTRL       = 4'h2;
   localparam logic [3:0] ADDR_CONF       = 4'h3;
   localparam logic [3:0] ADDR_STATUS     = 4'h4;
   localparam logic [3:0] ADDR_CHEN       = 4'h5;

   // Flag register fields
   localparam int unsigned F_ERR          = 0;
   localparam int unsigned F_POR          = 1;
   localparam int unsigned F_LOWSUP       = 2;
   localparam int unsigned F_SUPUV        = 3;
   localparam int unsigned F_REF          = 4;
   localparam int unsigned F_PRETH        = 5;
   localparam int unsigned F_OT           = 6;
   localparam int unsigned F_OUT          = 7;

   // Control register fields
   localparam int unsigned C_FAULT_CLR    = 0;
   localparam int unsigned C_POR_CLR      = 1;

   // Config register fields
   localparam int unsigned CF_LOWSUP_LSB  = 0;
   localparam int unsigned CF_RETRY_LSB   = 8;
   localparam int unsigned CF_BLANK_LSB   = 16;

   // Reset values
   localparam logic [4:0]  LOWSUP_RST     = 5'h00;
   localparam logic [3:0]  RETRY_RST      = 4'h0;
   localparam logic [6:0]  RETRY_NUM_RST  = 7'h04;
   localparam logic [7:0]  BLANK_RST      = 8'h28;
   localparam logic [15:0] CHEN_RST       = 16'hFFFF;
   localparam logic [4:0]  LOWSUP_MAX     = 5'h1F;

   // Low-supply threshold in volts: base plus code
   localparam int unsigned LOWSUP_BASE_V  = 4;
   localparam int unsigned LOWSUP_TOP_V   = 35;

   // Retry current: (code*4 + 4) / 64 of full range
   localparam int unsigned RETRY_MUL      = 4;
   localparam int unsigned RETRY_ADD      = 4;
   localparam int unsigned RETRY_DIV      = 64;

   // Timing
   localparam int unsigned RETRY_PERIOD_MS = 10;
   localparam int unsigned RETRY_CYC       = CLK_HZ / 1000 * RETRY_PERIOD_MS;
   localparam int unsigned OPEN_DEG_NS     = 2000;
   localparam int unsigned OPEN_DEG_CYC    = (OPEN_DEG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BLANK_UNIT_CYC  = 1;
   localparam int unsigned RETRY_PULSE_CYC = 40;

endpackage : ffs_pkg

//--- rtl/ffs_supervisor.sv
// Fail-safe fault supervisor: flag latching, error pin, channel gating and open retry
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ffs_supervisor #(
   parameter int unsigned RETRY_CYCLES = ffs_pkg::RETRY_CYC
) (
   // Clock and reset
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_reset,
   // Avalon-MM slave
   input  wire logic [3:0]               i_avs_address,
   input  wire logic                     i_avs_read,
   input  wire logic                     i_avs_write,
   input  wire logic [31:0]              i_avs_writedata,
   input  wire logic [3:0]               i_avs_byteenable,
   output logic      [31:0]              o_avs_readdata,
   output logic                          o_avs_waitrequest,
   // Analog comparator results
   input  wire logic [5:0]               i_supply_volts,
   input  wire logic                     i_supply_uv,
   input  wire logic                     i_ref_open,
   input  wire logic                     i_ref_short,
   input  wire logic                     i_prethermal,
   input  wire logic                     i_overtemp1,
   input  wire logic                     i_overtemp2,
   input  wire logic [ffs_pkg::NCH-1:0]  i_headroom_low,
   input  wire logic [ffs_pkg::NCH-1:0]  i_pwm_on,
   // Outputs
   output logic                          o_err_n_out,
   output logic                          o_err_n_oe_n,
   output logic [ffs_pkg::NCH-1:0]       o_channel_output_en,
   output logic [ffs_pkg::NCH-1:0]       o_retry_pulse,
   output logic [6:0]                    o_retry_current_num,
   output logic                          o_regulator_en,
   output logic                          o_low_supply
);

   localparam int unsigned NCH = ffs_pkg::NCH;

   typedef enum logic [1:0] {ST_IDLE, ST_ACK} ffs_bus_t;

   // Registers
   logic [7:0]      flags_q;
   logic [NCH-1:0]  channel_open_flag_q;
   logic [1:0]      ctrl_q;
   logic [4:0]      low_supply_threshold_sel_q;
   logic [3:0]      retry_current_code_q;
   logic [7:0]      blank_q;
   logic [NCH-1:0]  chen_q;
   logic [NCH-1:0]  retry_active_q;
   logic [31:0]     retry_cnt_q;
   logic [6:0]      pulse_cnt_q;
   logic [NCH-1:0]  retry_pulse_q;
   logic            ot2_shut_q;
   logic [31:0]     rdata_q;
   ffs_bus_t        bus_q;

   logic            low_supply;
   logic            ref_fault;
   logic            wr_ack;
   logic            fault_clear_bit;
   logic            power_on_clear_bit;
   logic            any_retry;
   logic            global_off;
   logic [5:0]      lowsup_volts;
   logic [31:0]     conf_wr;
   logic [31:0]     chen_wr;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // Byte lanes merged onto the current contents before the write lands
   assign conf_wr = merge_be({8'h00, blank_q, 4'h0, retry_current_code_q, 3'h0, low_supply_threshold_sel_q},
                             i_avs_writedata, i_avs_byteenable);
   assign chen_wr = merge_be({16'h0000, chen_q}, i_avs_writedata, i_avs_byteenable);

   // Code saturates so the level never passes the top of the range
   assign lowsup_volts = (low_supply_threshold_sel_q > 5'(ffs_pkg::LOWSUP_TOP_V - ffs_pkg::LOWSUP_BASE_V))
                       ? 6'(ffs_pkg::LOWSUP_TOP_V)
                       : 6'(low_supply_threshold_sel_q) + 6'(ffs_pkg::LOWSUP_BASE_V);
   assign low_supply   = i_supply_volts < lowsup_volts;
   assign ref_fault    = i_ref_open | i_ref_short;

   // One-cycle wait state; every access is answered on the second edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         bus_q <= ST_IDLE;
      end
      else
      begin
         unique case (bus_q)
            ST_IDLE: if (i_avs_read | i_avs_write) bus_q <= ST_ACK;
            ST_ACK:  bus_q <= ST_IDLE;
         endcase
      end
   end

   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & (bus_q == ST_IDLE);
   assign wr_ack            = i_avs_write & (bus_q == ST_ACK);

   // Clear bits hold for one cycle, then drop by themselves
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ctrl_q <= 2'h0;
      end
      else if (wr_ack && i_avs_address == ffs_pkg::ADDR_CTRL && i_avs_byteenable[0])
      begin
         ctrl_q <= i_avs_writedata[1:0];
      end
      else
      begin
         ctrl_q <= 2'h0;
      end
   end

   assign fault_clear_bit    = ctrl_q[ffs_pkg::C_FAULT_CLR];
   assign power_on_clear_bit = ctrl_q[ffs_pkg::C_POR_CLR];

   // Configuration registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset | ot2_shut_q)
      begin
         low_supply_threshold_sel_q <= ffs_pkg::LOWSUP_RST;
         retry_current_code_q       <= ffs_pkg::RETRY_RST;
         blank_q                    <= ffs_pkg::BLANK_RST;
         chen_q                     <= ffs_pkg::CHEN_RST;
      end
      else if (wr_ack && i_avs_address == ffs_pkg::ADDR_CONF)
      begin
         blank_q                    <= conf_wr[ffs_pkg::CF_BLANK_LSB +: 8];
         retry_current_code_q       <= conf_wr[ffs_pkg::CF_RETRY_LSB +: 4];
         low_supply_threshold_sel_q <= conf_wr[ffs_pkg::CF_LOWSUP_LSB +: 5];
      end
      else if (wr_ack && i_avs_address == ffs_pkg::ADDR_CHEN)
      begin
         chen_q <= chen_wr[NCH-1:0];
      end
   end

   // Second overtemperature: regulator off until the condition drops, then full restart
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         ot2_shut_q <= 1'b0;
      end
      else
      begin
         ot2_shut_q <= i_overtemp2;
      end
   end

   // Open detection with blanking plus deglitch per channel
   logic [NCH-1:0] open_det;
   logic [NCH-1:0] open_gone;
   generate
      for (genvar c = 0; c < NCH; c++)
      begin : g_ch
         logic [9:0] cnt_q;
         logic [9:0] gcnt_q;
         logic [9:0] lim;
         assign lim = 10'(blank_q) + 10'(ffs_pkg::OPEN_DEG_CYC);
         // Count only while PWM is on and the supply is good
         always_ff @(posedge i_ref_clk)
         begin
            if (i_reset || !i_pwm_on[c] || low_supply || !i_headroom_low[c] || !chen_q[c])
            begin
               cnt_q <= 10'h000;
            end
            else if (cnt_q != lim)
            begin
               cnt_q <= cnt_q + 10'h001;
            end
         end
         assign open_det[c] = (cnt_q == lim) & i_headroom_low[c] & i_pwm_on[c] & ~low_supply;
         always_ff @(posedge i_ref_clk)
         begin
            if (i_reset || !i_pwm_on[c] || i_headroom_low[c])
            begin
               gcnt_q <= 10'h000;
            end
            else if (gcnt_q != lim)
            begin
               gcnt_q <= gcnt_q + 10'h001;
            end
         end
         assign open_gone[c] = (gcnt_q == lim) & ~i_headroom_low[c] & i_pwm_on[c];
      end
   endgenerate

   // Retry state per channel
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset | ot2_shut_q)
      begin
         retry_active_q <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            if (open_gone[c] || low_supply)
            begin
               retry_active_q[c] <= 1'b0;
            end
            else if (open_det[c])
            begin
               retry_active_q[c] <= 1'b1;
            end
         end
      end
   end

   assign any_retry = |retry_active_q;

   // Retry period timer and pulse width
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset || !any_retry)
      begin
         retry_cnt_q   <= 32'h0000_0000;
         pulse_cnt_q   <= 7'h00;
         retry_pulse_q <= '0;
      end
      else
      begin
         if (retry_cnt_q >= 32'(RETRY_CYCLES - 1))
         begin
            retry_cnt_q <= 32'h0000_0000;
            pulse_cnt_q <= 7'(ffs_pkg::RETRY_PULSE_CYC);
         end
         else
         begin
            retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
            if (pulse_cnt_q != 7'h00)
            begin
               pulse_cnt_q <= pulse_cnt_q - 7'h01;
            end
         end
         retry_pulse_q <= (pulse_cnt_q != 7'h00) ? (retry_active_q & ~{NCH{global_off}}) : '0;
      end
   end

   // Latched flags; a live condition wins over a clear
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset | ot2_shut_q)
      begin
         flags_q                <= 8'h00;
         flags_q[ffs_pkg::F_POR] <= 1'b1;
         flags_q[ffs_pkg::F_ERR] <= 1'b1;
         channel_open_flag_q    <= '0;
      end
      else
      begin
         for (int c = 0; c < NCH; c++)
         begin
            channel_open_flag_q[c] <= open_det[c] | (channel_open_flag_q[c] & ~fault_clear_bit);
         end
         flags_q[ffs_pkg::F_LOWSUP] <= low_supply | (flags_q[ffs_pkg::F_LOWSUP] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_SUPUV]  <= i_supply_uv | (flags_q[ffs_pkg::F_SUPUV] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_REF]    <= ref_fault | (flags_q[ffs_pkg::F_REF] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_PRETH]  <= i_prethermal | (flags_q[ffs_pkg::F_PRETH] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_OT]     <= i_overtemp1 | (flags_q[ffs_pkg::F_OT] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_OUT]    <= (|open_det) | (flags_q[ffs_pkg::F_OUT] & ~fault_clear_bit);
         flags_q[ffs_pkg::F_POR]    <= flags_q[ffs_pkg::F_POR] & ~power_on_clear_bit;
         flags_q[ffs_pkg::F_ERR]    <= low_supply | i_supply_uv | ref_fault | i_prethermal | i_overtemp1
                                     | (|open_det)
                                     | (flags_q[ffs_pkg::F_ERR] & ~fault_clear_bit & ~power_on_clear_bit);
      end
   end

   // Outputs are gated while any global fault is live, and recover with it
   assign global_off = i_supply_uv | ref_fault | i_overtemp1 | ot2_shut_q;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         o_channel_output_en <= '0;
         o_retry_pulse       <= '0;
         o_retry_current_num <= ffs_pkg::RETRY_NUM_RST;
         o_regulator_en      <= 1'b1;
         o_low_supply        <= 1'b0;
         o_err_n_oe_n        <= 1'b1;
      end
      else
      begin
         o_channel_output_en <= global_off ? '0 : (chen_q & ~retry_active_q);
         // A channel leaving retry drops its pulse in the cycle its normal drive returns
         o_retry_pulse       <= retry_pulse_q & retry_active_q;
         o_retry_current_num <= 7'(retry_current_code_q) * 7'(ffs_pkg::RETRY_MUL)
                              + 7'(ffs_pkg::RETRY_ADD);
         o_regulator_en      <= ~i_overtemp2;
         o_low_supply        <= low_supply;
         // Pin held while the condition is live, released on recovery
         o_err_n_oe_n        <= ~(i_supply_uv | ref_fault | i_overtemp1 | i_overtemp2 | any_retry);
      end
   end

   assign o_err_n_out = 1'b0;

   // Read data
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (i_avs_read && bus_q == ST_IDLE)
      begin
         unique case (i_avs_address)
            ffs_pkg::ADDR_FLAGS:      rdata_q <= {24'h000000, flags_q};
            ffs_pkg::ADDR_OPEN_FLAGS: rdata_q <= {16'h0000, channel_open_flag_q};
            ffs_pkg::ADDR_CTRL:       rdata_q <= {30'h00000000, ctrl_q};
            ffs_pkg::ADDR_CONF:       rdata_q <= {8'h00, blank_q, 4'h0, retry_current_code_q,
                                                  3'h0, low_supply_threshold_sel_q};
            ffs_pkg::ADDR_STATUS:     rdata_q <= {retry_active_q, 15'h0000, low_supply};
            ffs_pkg::ADDR_CHEN:       rdata_q <= {16'h0000, chen_q};
            default:                  rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign o_avs_readdata = rdata_q;

endmodule : ffs_supervisor
`default_nettype wire

//--- verif/ffs_master_model.sv
// Bus master model standing in for the controller that clears flags
`timescale 1ns/1ps
`default_nettype none
module ffs_master_model (
   // Clock
   input  wire logic        i_ref_clk,
   // Slave answer
   input  wire logic        i_waitrequest,
   input  wire logic [31:0] i_readdata,
   // Request
   output logic      [3:0]  o_address,
   output logic             o_read,
   output logic             o_write,
   output logic      [31:0] o_writedata
);
   initial
   begin
      o_address = 4'h0;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
   end

   // Call just after a rising edge; holds the request until waitrequest is seen low
   task automatic bus_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      o_address <= a;
      o_write <= wr;
      o_read <= !wr;
      o_writedata <= d;
      @(posedge i_ref_clk);
      while (i_waitrequest !== 1'b0) @(posedge i_ref_clk);
      q = i_readdata;
      // Released lines show the inverse so a stale value cannot pass
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_address <= ~a;
      o_writedata <= ~d;
      @(posedge i_ref_clk);
   endtask : bus_cycle
endmodule : ffs_master_model
`default_nettype wire

//--- verif/ffs_supervisor_checker.sv
// Pin-level checks for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module ffs_supervisor_checker #(
   parameter int unsigned RETRY_CYCLES = ffs_pkg::RETRY_CYC
) (
   input wire logic                    i_ref_clk,
   input wire logic                    i_reset,
   input wire logic                    i_supply_uv,
   input wire logic                    i_ref_open,
   input wire logic                    i_ref_short,
   input wire logic                    i_overtemp1,
   input wire logic                    i_overtemp2,
   input wire logic                    o_err_n_out,
   input wire logic                    o_err_n_oe_n,
   input wire logic [ffs_pkg::NCH-1:0] o_channel_output_en,
   input wire logic [ffs_pkg::NCH-1:0] o_retry_pulse,
   input wire logic [6:0]              o_retry_current_num,
   input wire logic                    o_regulator_en
);
   logic [15:0] width_q;

   // Length of the current retry pulse in cycles
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset || !(|o_retry_pulse)) width_q <= 16'h0;
      else width_q <= width_q + 16'h1;
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   a_uv_pin_low: assert property (i_supply_uv |=> !o_err_n_oe_n)
      else $error("Error pin not low in undervoltage");
   a_uv_outputs_off: assert property (i_supply_uv |=> o_channel_output_en == 16'h0)
      else $error("Outputs on in undervoltage");
   a_ref_outputs_off: assert property ((i_ref_open || i_ref_short)
      |=> o_channel_output_en == 16'h0 && !o_err_n_oe_n)
      else $error("Reference fault not acted on");
   a_ot_outputs_off: assert property (i_overtemp1 |=> o_channel_output_en == 16'h0 && !o_err_n_oe_n)
      else $error("Overtemperature not acted on");
   a_ot_regulator_off: assert property (i_overtemp2 |=> !o_regulator_en && !o_err_n_oe_n)
      else $error("Regulator not shut down");
   a_pin_pull_only: assert property (o_err_n_out == 1'b0)
      else $error("Error pin driven high");
   a_retry_drive_off: assert property ((o_retry_pulse & o_channel_output_en) == 16'h0)
      else $error("Retried channel still regulated");
   a_retry_pin_low: assert property ($rose(|o_retry_pulse) |-> !o_err_n_oe_n)
      else $error("Error pin released while retrying");
   a_retry_code_range: assert property (o_retry_current_num[1:0] == 2'h0
      && o_retry_current_num >= 7'h04 && o_retry_current_num <= 7'h40)
      else $error("Retry current out of range");
   a_pulse_width: assert property ($fell(|o_retry_pulse) |-> width_q == 16'h0028)
      else $error("Retry pulse width wrong");
endmodule : ffs_supervisor_checker

bind ffs_supervisor ffs_supervisor_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_ffs_supervisor_checker (
   .i_ref_clk, .i_reset, .i_supply_uv, .i_ref_open, .i_ref_short, .i_overtemp1, .i_overtemp2, .o_err_n_out,
   .o_err_n_oe_n, .o_channel_output_en, .o_retry_pulse, .o_retry_current_num, .o_regulator_en);
`default_nettype wire

//--- verif/ffs_supervisor_test.sv
// Self-checking bench for the fail-safe fault supervisor
`timescale 1ns/1ps
`default_nettype none
module ffs_supervisor_test;
   localparam int unsigned RC = 200;
   logic        ref_clk;
   logic        reset = 1'b1;
   logic [3:0]  adr;
   logic        rd, wr, wreq, eo, eoe, regen, lows;
   logic [31:0] wd, rdat;
   logic [5:0]  volts = 6'h14;
   logic        uv = 1'b0, ropen = 1'b0, rshort = 1'b0, preth = 1'b0, ot1 = 1'b0, ot2 = 1'b0;
   logic [15:0] hl = 16'h0, pwm = 16'h0, chen, rp;
   logic [6:0]  rnum;
   logic [31:0] seed = 32'h6;
   logic [31:0] expq[$];
   int          mismatches = 0;
   int          total_checks = 0;
   int          fb[5] = '{ffs_pkg::F_SUPUV, ffs_pkg::F_REF, ffs_pkg::F_REF, ffs_pkg::F_PRETH, ffs_pkg::F_OT};

   ffs_supervisor #(.RETRY_CYCLES(RC)) u_ffs_supervisor (
      .i_ref_clk(ref_clk), .i_reset(reset), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_supply_volts(volts), .i_supply_uv(uv), .i_ref_open(ropen), .i_ref_short(rshort),
      .i_prethermal(preth), .i_overtemp1(ot1), .i_overtemp2(ot2), .i_headroom_low(hl), .i_pwm_on(pwm),
      .o_err_n_out(eo), .o_err_n_oe_n(eoe), .o_channel_output_en(chen), .o_retry_pulse(rp),
      .o_retry_current_num(rnum), .o_regulator_en(regen), .o_low_supply(lows));

   ffs_master_model u_ffs_master_model (
      .i_ref_clk(ref_clk), .i_waitrequest(wreq), .i_readdata(rdat),
      .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wd));

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic bw(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_ffs_master_model.bus_cycle(1'b1, a, d, q);
   endtask : bw

   task automatic br(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      expq.push_back(e);
      u_ffs_master_model.bus_cycle(1'b0, a, 32'h0, q);
   endtask : br

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // Read data stand at the edge where waitrequest is low
   always @(posedge ref_clk)
      if (rd === 1'b1 && wreq === 1'b0 && expq.size() > 0) chk(rdat, expq.pop_front());

   initial
   begin
      tick(20000);
      mismatches++;
      stop_test();
   end

   initial
   begin
      logic [4:0] code;
      logic [5:0] v;
      int th;
      tick(2);
      reset <= 1'b0;
      tick(1);
      br(ffs_pkg::ADDR_FLAGS, 32'h03);
      bw(ffs_pkg::ADDR_FLAGS, 32'hFFFFFFFF);
      bw(ffs_pkg::ADDR_CTRL, 32'h2);
      br(ffs_pkg::ADDR_FLAGS, 32'h0);
      br(ffs_pkg::ADDR_CTRL, 32'h0);
      br(4'hF, 32'h0);
      $display("Test reset finished");
      for (int i = 0; i < 8; i++)
      begin
         code = 5'(rnd());
         v = 6'(rnd() % 40);
         bw(ffs_pkg::ADDR_CONF, {16'h0028, 11'h0, code});
         volts <= v;
         tick(3);
         th = 4 + code;
         if (th > 35) th = 35;
         chk(32'(lows), 32'(v < th));
      end
      bw(ffs_pkg::ADDR_CONF, 32'h0028_0005);
      volts <= 6'd8;
      tick(3);
      bw(ffs_pkg::ADDR_CTRL, 32'h1);
      br(ffs_pkg::ADDR_FLAGS, 32'h05);
      volts <= 6'd20;
      tick(3);
      br(ffs_pkg::ADDR_FLAGS, 32'h05);
      bw(ffs_pkg::ADDR_CTRL, 32'h1);
      br(ffs_pkg::ADDR_FLAGS, 32'h0);
      $display("Test low supply finished");
      bw(ffs_pkg::ADDR_CHEN, 32'h00FF);
      for (int i = 0; i < 5; i++)
      begin
         {uv, ropen, rshort, preth, ot1} <= 5'h10 >> i;
         tick(3);
         chk(32'({eoe, chen}), (i == 3) ? 32'h100FF : 32'h0);
         {uv, ropen, rshort, preth, ot1} <= 5'h0;
         tick(3);
         chk(32'({eoe, chen}), 32'h100FF);
         br(ffs_pkg::ADDR_FLAGS, 32'h1 | (32'h1 << fb[i]));
         bw(ffs_pkg::ADDR_CTRL, 32'h1);
         br(ffs_pkg::ADDR_FLAGS, 32'h0);
      end
      $display("Test faults finished");
      bw(ffs_pkg::ADDR_CONF, 32'h0028_0307);
      ot2 <= 1'b1;
      tick(3);
      chk(32'({regen, eoe}), 32'h0);
      ot2 <= 1'b0;
      tick(3);
      chk(32'({regen, eoe}), 32'h3);
      br(ffs_pkg::ADDR_CONF, {8'h0, ffs_pkg::BLANK_RST, 4'h0, ffs_pkg::RETRY_RST, 3'h0, ffs_pkg::LOWSUP_RST});
      br(ffs_pkg::ADDR_CHEN, 32'hFFFF);
      br(ffs_pkg::ADDR_FLAGS, 32'h03);
      bw(ffs_pkg::ADDR_CTRL, 32'h2);
      br(ffs_pkg::ADDR_FLAGS, 32'h0);
      $display("Test shutdown finished");
      bw(ffs_pkg::ADDR_CONF, 32'h0008_0514);
      hl <= 16'h0008;
      pwm <= 16'hFFFF;
      tick(200);
      br(ffs_pkg::ADDR_OPEN_FLAGS, 32'h0);
      bw(ffs_pkg::ADDR_CONF, 32'h0008_0500);
      tick(130);
      chk(32'({eoe, chen}), 32'h0FFF7);
      chk(32'(rnum), 32'd24);
      br(ffs_pkg::ADDR_OPEN_FLAGS, 32'h8);
      for (int k = 0; k < RC + 60 && rp[3] !== 1'b1; k++) tick(1);
      chk(32'(rp), 32'h8);
      hl <= 16'h0;
      tick(150);
      chk(32'({eoe, chen}), 32'h1FFFF);
      br(ffs_pkg::ADDR_FLAGS, 32'h85);
      br(ffs_pkg::ADDR_OPEN_FLAGS, 32'h8);
      bw(ffs_pkg::ADDR_CTRL, 32'h1);
      br(ffs_pkg::ADDR_FLAGS, 32'h0);
      br(ffs_pkg::ADDR_OPEN_FLAGS, 32'h0);
      hl <= 16'h0008;
      tick(100);
      chk(32'({eoe, chen}), 32'h0FFF7);
      volts <= 6'd2;
      tick(3);
      chk(32'({eoe, chen}), 32'h1FFFF);
      $display("Test open circuit finished");
      stop_test();
   end
endmodule : ffs_supervisor_test
`default_nettype wire
